// [design/pcrc_defines.svh]
`ifndef PCRC_DEFINES_SVH
`define PCRC_DEFINES_SVH
// Contract
// - control/status register clears on hard reset, keeps contents on soft reset.
// - power-event status bit 15 is sticky, set regardless of enable; write one clears.
// - status bit 15 and enable bit 8 mirror the power-management config bits.
// - enable bit 8 allows the shared pin; when clear the pin stays inactive.
// - power-event enable can be loaded from the serial EEPROM auto-load.
// - select bit 0 set gives clock-run function; clear gives power-event output.
// - clock-run pin is open-drain, only pulls low, never drives high.
// - pin stays input unless released high while a transfer is still pending.
// - clock stopped or slowed and bus needed raises a clock-start request.
// - on start or continue, pull pin low for two rising edges, then release.
// - assert only after sampling the pin deasserted on two consecutive edges.
// - after an event completes, do not block the system stopping the clock.
// - with enable clear, never assert the pin for clock start or continue.
// - receive clock mux follows clock-run line between PCI and reference clock; the code does so only with select bit 0 set, else it stays on PCI.
// - central resource signals clock state on the line; devices request restart.

`define PCRC_CTRL_STATUS_OFFSET 8'h3c
`define PCRC_CTRL_STATUS_RESET  32'h0000_0000
`define PCRC_STATUS_BIT         15
`define PCRC_ENABLE_BIT         8
`define PCRC_CLKRUN_SEL_BIT     0
`define PCRC_ASSERT_EDGES       2
`define PCRC_DEASSERT_SAMPLES   2
`define PCRC_CENTRAL_HOLD_EDGES 4
`endif

// [design/pcrc_pkg.sv]
package pcrc_pkg;
	typedef enum logic [1:0]
	{
		PCRC_IDLE   = 2'b00,
		PCRC_ASSERT = 2'b01,
		PCRC_DONE   = 2'b11
	} pcrc_state_type;
endpackage : pcrc_pkg

// [design/pcrc_pin_if.sv]
`timescale 1ns/1ps
interface pcrc_pin_if;
	logic pin_level;
	logic high_run_done;
	modport mon
	(
		input  pin_level,
		output high_run_done
	);
	modport ctrl
	(
		output pin_level,
		input  high_run_done
	);
endinterface : pcrc_pin_if

// [design/pcrc_pin_monitor.sv]
`timescale 1ns/1ps
`include "pcrc_defines.svh"
module pcrc_pin_monitor
	import pcrc_pkg::*;
#(
	parameter int SAMPLES = `PCRC_DEASSERT_SAMPLES
)
(
	input wire logic clk,      // pci clock
	input wire logic rst_n,    // hard reset, async
	input wire logic soft_rst, // soft reset, sync
	pcrc_pin_if.mon  pin       // sampled line and result
);
	logic [2:0] high_cnt;

	// saturating run of consecutive high samples
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			high_cnt <= 3'h0;
		else if (soft_rst || !pin.pin_level)
			high_cnt <= 3'h0;
		else if (high_cnt < 3'(SAMPLES))
			high_cnt <= high_cnt + 3'h1;
	end

	assign pin.high_run_done = (high_cnt >= 3'(SAMPLES));
endmodule : pcrc_pin_monitor

// [design/pcrc_clock_run_ctrl.sv]
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "pcrc_defines.svh"
module pcrc_clock_run_ctrl
	import pcrc_pkg::*;
#(
	parameter int ASSERT_EDGES = `PCRC_ASSERT_EDGES
)
(
	input  wire logic        CLK,          // pci clock, 25 MHz
	input  wire logic        RST_N,        // hard reset, async, active low
	input  wire logic        SOFT_RST,     // soft reset, sync, active high
	input  wire logic [7:0]  ADDR,         // register byte address
	input  wire logic [31:0] WDATA,        // register write data
	input  wire logic        WR,           // write strobe
	input  wire logic        RD,           // read strobe
	output logic      [31:0] RDATA,        // read data, cycle after RD
	input  wire logic        CFG_WR,       // config power-mgmt register write
	input  wire logic [15:0] CFG_WDATA,    // config write data, bits 15 and 8 used
	output logic             CFG_STATUS,   // mirrored status to config space
	output logic             CFG_ENABLE,   // mirrored enable to config space
	input  wire logic        EE_LOAD,      // eeprom auto-load strobe
	input  wire logic        EE_ENABLE,    // eeprom value for enable bit
	input  wire logic        PME_EVENT,    // power-event logic pulse
	input  wire logic        WAKE_PKT,     // wake packet seen, pulse
	input  wire logic        RX_DMA_READY, // receive data waiting for dma
	input  wire logic        XFER_PENDING, // transmit or receive unfinished
	input  wire logic        PIN_IN,       // shared pin level, low is active
	output logic             PIN_OUT,      // shared pin drive value
	output logic             PIN_OE,       // shared pin drive enable
	output logic             RX_CLK_REF    // rx mux: 1 reference clock, 0 pci
);
	logic           status;
	logic           enable;
	logic           clkrun_sel;
	logic           wake_req;
	logic           reg_hit;
	logic           status_clear;
	logic           start_req;
	logic           continue_req;
	logic [2:0]     edge_cnt;
	pcrc_state_type state;
	pcrc_state_type next_state;
	pcrc_pin_if     pin_bus ();

	assign pin_bus.pin_level = PIN_IN;

	pcrc_pin_monitor #(
		.SAMPLES (`PCRC_DEASSERT_SAMPLES)
	) u_monitor (
		.clk      (CLK),
		.rst_n    (RST_N),
		.soft_rst (SOFT_RST),
		.pin      (pin_bus)
	);

	assign reg_hit      = (ADDR == `PCRC_CTRL_STATUS_OFFSET);
	assign status_clear = (WR && reg_hit && WDATA[`PCRC_STATUS_BIT])
	                    || (CFG_WR && CFG_WDATA[`PCRC_STATUS_BIT]);

	// soft reset leaves the register alone, only hard reset clears it
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			status <= 1'b0;
		else if (PME_EVENT)
			status <= 1'b1;
		else if (status_clear)
			status <= 1'b0;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			enable <= 1'b0;
		else if (EE_LOAD)
			enable <= EE_ENABLE;
		else if (WR && reg_hit)
			enable <= WDATA[`PCRC_ENABLE_BIT];
		else if (CFG_WR)
			enable <= CFG_WDATA[`PCRC_ENABLE_BIT];
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			clkrun_sel <= 1'b0;
		else if (WR && reg_hit)
			clkrun_sel <= WDATA[`PCRC_CLKRUN_SEL_BIT];
	end

	// unmapped addresses and reserved bits read zero
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			RDATA <= 32'h0000_0000;
		else if (RD && reg_hit)
			RDATA <= {16'h0000, status, 6'h00, enable, 7'h00, clkrun_sel};
		else
			RDATA <= 32'h0000_0000;
	end

	assign CFG_STATUS = status;
	assign CFG_ENABLE = enable;

	// wake packet held until a start request has been served
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			wake_req <= 1'b0;
		else if (WAKE_PKT)
			wake_req <= 1'b1;
		else if (SOFT_RST || (state == PCRC_DONE))
			wake_req <= 1'b0;
	end

	// line high means the central resource has stopped or slowed the clock
	assign start_req    = wake_req || RX_DMA_READY;
	assign continue_req = XFER_PENDING;

	always_comb
	begin
		next_state = state;
		case (state)
			PCRC_IDLE:
				if (enable && clkrun_sel && pin_bus.high_run_done
				    && (start_req || continue_req))
					next_state = PCRC_ASSERT;
			PCRC_ASSERT:
				if (!enable || !clkrun_sel)
					next_state = PCRC_IDLE;
				else if (edge_cnt >= 3'(ASSERT_EDGES - 1))
					next_state = PCRC_DONE;
			PCRC_DONE:
				next_state = PCRC_IDLE;
			default:
				next_state = PCRC_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			state <= PCRC_IDLE;
		else if (SOFT_RST)
			state <= PCRC_IDLE;
		else
			state <= next_state;
	end

	// rising edges seen while pulling the line low
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			edge_cnt <= 3'h0;
		else if (state == PCRC_ASSERT)
			edge_cnt <= edge_cnt + 3'h1;
		else
			edge_cnt <= 3'h0;
	end

	// open drain: drive value is always low, only the enable moves
	assign PIN_OUT = 1'b0;
	always_comb
	begin
		if (!enable)
			PIN_OE = 1'b0;
		else if (clkrun_sel)
			PIN_OE = (state == PCRC_ASSERT);
		else
			PIN_OE = status;
	end

	// with select bit 0 set, mux select follows every swing of the line, ours or another device's; with it clear it stays 0
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			RX_CLK_REF <= 1'b0;
		else
			RX_CLK_REF <= clkrun_sel && PIN_IN;
	end

	sequence s_pull_two;
		PIN_OE [*2];
	endsequence

	sequence s_release;
		!PIN_OE;
	endsequence

	property p_soft_keep;
		@(posedge CLK) disable iff (!RST_N)
		SOFT_RST && !WR && !CFG_WR && !EE_LOAD |=> $stable(enable) && $stable(clkrun_sel);
	endproperty
	a_soft_keep: assert property (p_soft_keep)
		else $error("soft reset changed the register");

	property p_status_set;
		@(posedge CLK) disable iff (!RST_N)
		PME_EVENT |=> status;
	endproperty
	a_status_set: assert property (p_status_set)
		else $error("power event did not set status");

	property p_status_clear;
		@(posedge CLK) disable iff (!RST_N)
		WR && reg_hit && WDATA[`PCRC_STATUS_BIT] && !PME_EVENT |=> !status;
	endproperty
	a_status_clear: assert property (p_status_clear)
		else $error("write one did not clear status");

	property p_cfg_mirror;
		@(posedge CLK) disable iff (!RST_N)
		CFG_WR && !EE_LOAD && !WR |=> enable == $past(CFG_WDATA[`PCRC_ENABLE_BIT]);
	endproperty
	a_cfg_mirror: assert property (p_cfg_mirror)
		else $error("config write not mirrored to enable");

	property p_enable_gate;
		@(posedge CLK) disable iff (!RST_N)
		!enable |-> !PIN_OE;
	endproperty
	a_enable_gate: assert property (p_enable_gate)
		else $error("pin driven with enable clear");

	property p_ee_load;
		@(posedge CLK) disable iff (!RST_N)
		EE_LOAD |=> enable == $past(EE_ENABLE);
	endproperty
	a_ee_load: assert property (p_ee_load)
		else $error("eeprom load of enable failed");

	property p_pme_mode;
		@(posedge CLK) disable iff (!RST_N)
		!clkrun_sel && enable && status |-> PIN_OE;
	endproperty
	a_pme_mode: assert property (p_pme_mode)
		else $error("power event output not driven");

	property p_open_drain;
		@(posedge CLK) disable iff (!RST_N)
		PIN_OE |-> !PIN_OUT;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("pin driven high");

	property p_continue;
		@(posedge CLK) disable iff (!RST_N)
		state == PCRC_IDLE && enable && clkrun_sel && pin_bus.high_run_done
		&& XFER_PENDING && !SOFT_RST ##1 enable && clkrun_sel |-> PIN_OE;
	endproperty
	a_continue: assert property (p_continue)
		else $error("clock continue not requested");

	property p_two_edges;
		@(posedge CLK) disable iff (!RST_N)
		$rose(PIN_OE) && clkrun_sel && enable && !SOFT_RST
		##1 enable && clkrun_sel && !SOFT_RST
		|-> ##1 s_release;
	endproperty
	a_two_edges: assert property (p_two_edges)
		else $error("pull not released after two edges");

	property p_pull_length;
		@(posedge CLK) disable iff (!RST_N)
		state == PCRC_IDLE && next_state == PCRC_ASSERT && !SOFT_RST
		##1 enable && clkrun_sel && !SOFT_RST
		##1 enable && clkrun_sel
		|-> PIN_OE && $past(PIN_OE);
	endproperty
	a_pull_length: assert property (p_pull_length)
		else $error("pull shorter than two edges");

	property p_precheck;
		@(posedge CLK) disable iff (!RST_N)
		$rose(PIN_OE) && clkrun_sel |-> $past(PIN_IN, 2) && $past(PIN_IN, 3);
	endproperty
	a_precheck: assert property (p_precheck)
		else $error("asserted without two deasserted samples");

	property p_no_block;
		@(posedge CLK) disable iff (!RST_N)
		state == PCRC_DONE |=> state == PCRC_IDLE && !PIN_OE || !clkrun_sel;
	endproperty
	a_no_block: assert property (p_no_block)
		else $error("line held after event completed");

	property p_rx_mux;
		@(posedge CLK) disable iff (!RST_N)
		clkrun_sel |=> RX_CLK_REF == $past(PIN_IN);
	endproperty
	a_rx_mux: assert property (p_rx_mux)
		else $error("receive clock mux not following line");

	property p_reserved_zero;
		@(posedge CLK) disable iff (!RST_N)
		RD |=> RDATA[31:16] == 16'h0000 && RDATA[14:9] == 6'h00 && RDATA[7:1] == 7'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bits read nonzero");
endmodule : pcrc_clock_run_ctrl

// [tb/pcrc_central_model.sv]
`timescale 1ns/1ps
module pcrc_central_model
(
	input  wire logic clk,      // pci clock
	input  wire logic rst_n,    // hard reset, active low
	input  wire logic stop_req, // 1: clock slowed, line let go
	input  wire logic dev_pull, // device pulls line low
	output logic      line      // resolved line level
);
	logic [2:0] hold;

	// once the device pulls, keep the line low for four edges
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			hold <= 3'h0;
		else if (dev_pull && hold == 3'h0)
			hold <= 3'h4;
		else if (hold != 3'h0)
			hold <= hold - 3'h1;
	end

	// pull-up gives high only when no party drives low
	assign line = ~(dev_pull | (hold != 3'h0) | ~stop_req);
endmodule : pcrc_central_model

// [tb/pcrc_clock_run_ctrl_test.sv]
`timescale 1ns/1ps
module pcrc_clock_run_ctrl_test;
	logic        CLK, RST_N, SOFT_RST, WR, RD, CFG_WR, EE_LOAD, EE_ENABLE, PME_EVENT;
	logic        WAKE_PKT, RX_DMA_READY, XFER_PENDING, PIN_IN, PIN_OUT, PIN_OE;
	logic        RX_CLK_REF, CFG_STATUS, CFG_ENABLE, stop_req;
	logic [7:0]  ADDR;
	logic [31:0] WDATA, RDATA;
	logic [15:0] CFG_WDATA;
	int          n_errors, checked, cyc, hi;

	pcrc_clock_run_ctrl i_dut
	(
		.CLK(CLK), .RST_N(RST_N), .SOFT_RST(SOFT_RST), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .CFG_WR(CFG_WR), .CFG_WDATA(CFG_WDATA),
		.CFG_STATUS(CFG_STATUS), .CFG_ENABLE(CFG_ENABLE), .EE_LOAD(EE_LOAD),
		.EE_ENABLE(EE_ENABLE), .PME_EVENT(PME_EVENT), .WAKE_PKT(WAKE_PKT),
		.RX_DMA_READY(RX_DMA_READY), .XFER_PENDING(XFER_PENDING), .PIN_IN(PIN_IN),
		.PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .RX_CLK_REF(RX_CLK_REF)
	);

	pcrc_central_model i_central
	(
		.clk(CLK), .rst_n(RST_N), .stop_req(stop_req),
		.dev_pull(PIN_OE & ~PIN_OUT), .line(PIN_IN)
	);

	initial
	begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	initial
	begin
		cyc = 0;
		forever
		begin
			@(posedge CLK);
			cyc++;
			if (cyc == 5000)
			begin
				n_errors++;
				wrap_up();
			end
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		ADDR  <= a;
		WDATA <= d;
		WR    <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge CLK);
		ADDR <= a;
		RD   <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 chk("rdata", exp, RDATA);
	endtask : rd

	// raise one request kind, count edges at which the pin was driven
	task automatic run_event(input int kind, input int exp);
		int n;
		@(posedge CLK);
		XFER_PENDING <= (kind == 0);
		RX_DMA_READY <= (kind == 1);
		WAKE_PKT     <= (kind == 2);
		@(posedge CLK);
		WAKE_PKT <= 1'b0;
		hi = 0;
		// look mid-cycle, where the combinational enable has settled
		for (n = 0; n < 20; n++)
		begin
			@(negedge CLK);
			if (PIN_OE === 1'b1)
			begin
				hi++;
				chk("pin_out", 32'h0, {31'h0, PIN_OUT});
			end
			@(posedge CLK);
			if (hi > 0)
			begin
				XFER_PENDING <= 1'b0;
				RX_DMA_READY <= 1'b0;
			end
		end
		XFER_PENDING <= 1'b0;
		RX_DMA_READY <= 1'b0;
		@(negedge CLK);
		chk("oe_cycles", exp, hi);
		chk("line_free", {31'h0, stop_req}, {31'h0, PIN_IN});
		@(posedge CLK);
	endtask : run_event

	initial
	begin
		{RST_N, SOFT_RST, WR, RD, CFG_WR, EE_LOAD, EE_ENABLE, PME_EVENT} = '0;
		{WAKE_PKT, RX_DMA_READY, XFER_PENDING, stop_req} = '0;
		ADDR = 8'h00;
		WDATA = 32'h0;
		CFG_WDATA = 16'h0;
		n_errors = 0;
		checked = 0;
		repeat (4) @(posedge CLK);
		RST_N <= 1'b1;
		rd(8'h3c, 32'h0);
		wr(8'h3c, 32'hffff_ffff);
		rd(8'h3c, 32'h0000_0101);
		rd(8'h40, 32'h0);
		$display("test registers done");
		@(posedge CLK) PME_EVENT <= 1'b1;
		@(posedge CLK) PME_EVENT <= 1'b0;
		rd(8'h3c, 32'h0000_8101);
		chk("cfg_status", 32'h1, {31'h0, CFG_STATUS});
		wr(8'h3c, 32'h0000_0100);
		@(posedge CLK) #1 chk("pme_oe", 32'h1, {31'h0, PIN_OE});
		@(posedge CLK) CFG_WR <= 1'b1;
		CFG_WDATA <= 16'h8000;
		@(posedge CLK) CFG_WR <= 1'b0;
		rd(8'h3c, 32'h0);
		@(posedge CLK) PME_EVENT <= 1'b1;
		@(posedge CLK) PME_EVENT <= 1'b0;
		rd(8'h3c, 32'h0000_8000);
		chk("pme_off", 32'h0, {31'h0, PIN_OE});
		@(posedge CLK) EE_LOAD <= 1'b1;
		EE_ENABLE <= 1'b1;
		@(posedge CLK) EE_LOAD <= 1'b0;
		#1 chk("ee_enable", 32'h1, {31'h0, CFG_ENABLE});
		chk("pme_on", 32'h1, {31'h0, PIN_OE});
		@(posedge CLK) SOFT_RST <= 1'b1;
		@(posedge CLK) SOFT_RST <= 1'b0;
		rd(8'h3c, 32'h0000_8100);
		wr(8'h3c, 32'h0000_8101);
		rd(8'h3c, 32'h0000_0101);
		$display("test power event done");
		run_event(0, 0);
		stop_req <= 1'b1;
		repeat (3) @(posedge CLK);
		#1 chk("rx_ref", 32'h1, {31'h0, RX_CLK_REF});
		for (int k = 0; k < 3; k++)
			run_event(k, 2);
		wr(8'h3c, 32'h0000_0001);
		run_event(1, 0);
		stop_req <= 1'b0;
		repeat (2) @(posedge CLK);
		#1 chk("rx_pci", 32'h0, {31'h0, RX_CLK_REF});
		$display("test clock run done");
		wrap_up();
	end
endmodule : pcrc_clock_run_ctrl_test
